// ---- hw/bsrs_params.svh ----
// Timing constants for the bus sense start-up ramp sequencer
`ifndef BSRS_PARAMS_SVH
`define BSRS_PARAMS_SVH

// System clock period in ns (100 MHz)
`define BSRS_CLK_PERIOD_NS 10
// Nominal switching cycle length in ns
`define BSRS_CYCLE_NS 8000
// Switching cycle length in clocks
`define BSRS_CYCLE_CLKS (`BSRS_CYCLE_NS / `BSRS_CLK_PERIOD_NS)
// Start-up delay after bus enable, in us
`define BSRS_START_DELAY_US 1000
// Start-up delay in clocks (shortest-time style, rounds down)
`define BSRS_START_DELAY_CLKS ((`BSRS_START_DELAY_US * 1000) / `BSRS_CLK_PERIOD_NS)
// Nominal ramp interval in ms
`define BSRS_RAMP_MS 20
// Ramp interval in clocks
`define BSRS_RAMP_CLKS ((`BSRS_RAMP_MS * 1000000) / `BSRS_CLK_PERIOD_NS)
// Final ramp duty in percent
`define BSRS_RAMP_MAX_DUTY_PCT 95
// Initial ramp duty in percent
`define BSRS_RAMP_START_DUTY_PCT 5
// Least idle gap: rounded up so duty never passes the final value
`define BSRS_IDLE_MIN_CLKS \
    ((`BSRS_CYCLE_CLKS * (100 - `BSRS_RAMP_MAX_DUTY_PCT) + `BSRS_RAMP_MAX_DUTY_PCT - 1) / `BSRS_RAMP_MAX_DUTY_PCT)
// First idle gap of the ramp
`define BSRS_IDLE_START_CLKS \
    ((`BSRS_CYCLE_CLKS * (100 - `BSRS_RAMP_START_DUTY_PCT)) / `BSRS_RAMP_START_DUTY_PCT)
// Synchroniser reset value
`define BSRS_SYNC_RST 1'b0

`endif

// ---- hw/bsrs_pkg.sv ----
// Types for the bus sense start-up ramp sequencer
package bsrs_pkg;

    // Operating states of the sequencer
    typedef enum logic [2:0]
    {
        BSRS_GATED,
        BSRS_DELAY,
        BSRS_RAMP,
        BSRS_NORMAL,
        BSRS_FAULT
    } bsrs_state_type;

endpackage : bsrs_pkg

// ---- hw/bsrs_sync.sv ----
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`include "bsrs_params.svh"

module bsrs_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;  // First stage, read only by second stage
    logic [WIDTH-1:0] sync_q;  // Second stage, safe to use

    // Two stages; metastability settles in the first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= {WIDTH{`BSRS_SYNC_RST}};
            sync_q <= {WIDTH{`BSRS_SYNC_RST}};
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : bsrs_sync

// ---- hw/bsrs_sequencer.sv ----
// Start-up, ramp and bus protection sequencer for a burst-mode controller
`timescale 1ns/1ps
`include "bsrs_params.svh"

// Overview of operation
// - Start cycles only while bus above enable threshold
// - Bus undervoltage: finish cycle, then stop
// - Wait start-up delay after bus enable
// - Overvoltage latches shutdown, not self-clearing
// - Fault during cycle: finish, then latch
// - Fault while idle: latch immediately
// - Start-up delay expiry enters ramp-up
// - Ramp emits single cycles with idle gaps
// - Ramp idle gaps shrink progressively
// - Ramp idle gap falls linearly in time
// - Minimum idle gap caps final duty
// - Feedback low during ramp enters normal
// - Ramp interval end enters normal anyway
// - Normal mode allows back-to-back cycles
// - Run indicator high only in normal
// - Fault output mirrors latched fault state
// - Started cycles always run to completion
module bsrs_sequencer
    import bsrs_pkg::*;
#(
    parameter int CYCLE_CLKS       = `BSRS_CYCLE_CLKS,
    parameter int START_DELAY_CLKS = `BSRS_START_DELAY_CLKS,
    parameter int RAMP_CLKS        = `BSRS_RAMP_CLKS,
    parameter int IDLE_START_CLKS  = `BSRS_IDLE_START_CLKS,
    parameter int IDLE_MIN_CLKS    = `BSRS_IDLE_MIN_CLKS
)
(
    input  wire logic CLK_SYS,
    input  wire logic RST_N,
    input  wire logic BUS_UNDERVOLTAGE_GATE,
    input  wire logic BUS_OVERVOLTAGE_TRIP,
    input  wire logic REGULATION_FEEDBACK_INPUT,
    output logic      CYCLE_START,
    output logic      CYCLE_ACTIVE,
    output logic      RUN_INDICATOR,
    output logic      FAULT_LATCHED
);

    // Counter widths sized from the longest counts
    localparam int CW = (CYCLE_CLKS > 1) ? $clog2(CYCLE_CLKS) : 1;
    localparam int DW = $clog2(START_DELAY_CLKS + 1);
    localparam int RW = $clog2(RAMP_CLKS + 1);
    localparam int IW = $clog2(IDLE_START_CLKS + 1);
    // Clocks per one-clock shrink of the idle gap, at least one
    localparam int STEP_RAW  = RAMP_CLKS / (IDLE_START_CLKS - IDLE_MIN_CLKS);
    localparam int STEP_CLKS = (STEP_RAW < 1) ? 1 : STEP_RAW;
    localparam int SW = $clog2(STEP_CLKS + 1);

    logic           rst_meta_q;    // Reset release, first stage
    logic           rst_sync_q;    // Reset release, used by all logic
    logic           uv_ok;         // Bus above enable level, synchronised
    logic           ov_trip;       // Bus overvoltage, synchronised
    logic           fb_high;       // Feedback high, synchronised

    bsrs_state_type state_q;       // Operating state
    bsrs_state_type state_d;
    logic [DW-1:0]  dly_q;         // Start-up delay countdown
    logic [DW-1:0]  dly_d;
    logic [RW-1:0]  ramp_q;        // Ramp interval countdown
    logic [RW-1:0]  ramp_d;
    logic [SW-1:0]  step_q;        // Clocks to next idle shrink
    logic [SW-1:0]  step_d;
    logic [IW-1:0]  idle_len_q;    // Current ramp idle gap length
    logic [IW-1:0]  idle_len_d;
    logic [IW-1:0]  idle_q;        // Idle gap countdown
    logic [IW-1:0]  idle_d;
    logic           ov_pend_q;     // Overvoltage seen mid-cycle
    logic           ov_pend_d;

    logic [CW-1:0]  cyc_q;         // Switching cycle countdown
    logic [CW-1:0]  cyc_d;
    logic           act_q;         // Cycle in progress
    logic           act_d;
    logic           start_q;       // One-clock start marker
    logic           run_q;         // Run indicator register
    logic           run_d;
    logic           fault_q;       // Fault output register
    logic           fault_d;

    logic           cyc_end;       // Last clock of a running cycle
    logic           boundary;      // No running cycle carries on past this clock
    logic           fault_now;     // Overvoltage pending or present
    logic           start_cyc;     // Begin a cycle on the next edge

    // Reset: asserts at once, releases through two flops
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Pins arrive unclocked, so all three pass two flops
    bsrs_sync #(
        .WIDTH    (3)
    ) u_pin_sync (
        .clk      (CLK_SYS),
        .rst_n    (rst_sync_q),
        .async_in ({BUS_UNDERVOLTAGE_GATE, BUS_OVERVOLTAGE_TRIP, REGULATION_FEEDBACK_INPUT}),
        .sync_out ({uv_ok, ov_trip, fb_high})
    );

    // Cycle boundaries seen by the state logic
    always_comb
    begin
        cyc_end   = act_q && (cyc_q == '0);
        boundary  = !act_q || cyc_end;
        fault_now = ov_trip || ov_pend_q;
    end

    // Start decision: never on a bad bus, ramp waits for its gap
    always_comb
    begin
        start_cyc = 1'b0;
        if (uv_ok && !fault_now)
        begin
            case (state_q)
                BSRS_RAMP:
                begin
                    // Single cycles only, never contiguous
                    start_cyc = !act_q && (idle_q == '0) && fb_high;
                end
                BSRS_NORMAL:
                begin
                    // Feedback polled at each cycle end
                    start_cyc = boundary && fb_high;
                end
                default:
                begin
                    start_cyc = 1'b0;
                end
            endcase
        end
    end

    // Switching cycle engine; a started cycle always finishes
    always_comb
    begin
        cyc_d = cyc_q;
        act_d = act_q;
        if (start_cyc)
        begin
            act_d = 1'b1;
            cyc_d = CW'(CYCLE_CLKS - 1);
        end
        else if (cyc_end)
        begin
            act_d = 1'b0;
        end
        else if (act_q)
        begin
            cyc_d = cyc_q - 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            cyc_q   <= '0;
            act_q   <= 1'b0;
            start_q <= 1'b0;
        end
        else
        begin
            cyc_q   <= cyc_d;
            act_q   <= act_d;
            start_q <= start_cyc;
        end
    end

    // Sequencer state, delay, ramp timing and fault latch
    always_comb
    begin
        state_d    = state_q;
        dly_d      = dly_q;
        ramp_d     = ramp_q;
        step_d     = step_q;
        idle_len_d = idle_len_q;
        idle_d     = idle_q;
        ov_pend_d  = ov_pend_q;
        // Overvoltage inside a cycle is held until its end
        if (ov_trip && act_q && state_q != BSRS_FAULT)
        begin
            ov_pend_d = 1'b1;
        end
        case (state_q)
            BSRS_GATED:
            begin
                if (ov_trip)
                begin
                    state_d = BSRS_FAULT;
                end
                else if (uv_ok && !act_q)
                begin
                    state_d = BSRS_DELAY;
                    dly_d   = DW'(START_DELAY_CLKS - 1);
                end
            end
            BSRS_DELAY:
            begin
                if (ov_trip)
                begin
                    state_d = BSRS_FAULT;
                end
                else if (!uv_ok)
                begin
                    state_d = BSRS_GATED;
                end
                else if (dly_q == '0)
                begin
                    // Ramp starts with its first cycle at once
                    state_d    = BSRS_RAMP;
                    ramp_d     = RW'(RAMP_CLKS - 1);
                    step_d     = SW'(STEP_CLKS - 1);
                    idle_len_d = IW'(IDLE_START_CLKS);
                    idle_d     = '0;
                end
                else
                begin
                    dly_d = dly_q - 1'b1;
                end
            end
            BSRS_RAMP, BSRS_NORMAL:
            begin
                if (fault_now && boundary)
                begin
                    state_d = BSRS_FAULT;
                end
                else if (!uv_ok && boundary)
                begin
                    state_d = BSRS_GATED;
                end
                else if (state_q == BSRS_RAMP)
                begin
                    if (!fb_high)
                    begin
                        // Running cycle still completes in normal mode
                        state_d = BSRS_NORMAL;
                    end
                    else if (ramp_q == '0)
                    begin
                        state_d = BSRS_NORMAL;
                    end
                    else
                    begin
                        ramp_d = ramp_q - 1'b1;
                    end
                    // Gap shrinks one clock per fixed step of ramp time
                    if (step_q == '0)
                    begin
                        step_d = SW'(STEP_CLKS - 1);
                        if (idle_len_q > IW'(IDLE_MIN_CLKS))
                        begin
                            idle_len_d = idle_len_q - 1'b1;
                        end
                    end
                    else
                    begin
                        step_d = step_q - 1'b1;
                    end
                    // Idle gap after each cycle, never below the floor
                    if (cyc_end)
                    begin
                        idle_d = idle_len_q - 1'b1;
                    end
                    else if (!act_q && idle_q != '0)
                    begin
                        idle_d = idle_q - 1'b1;
                    end
                end
            end
            BSRS_FAULT:
            begin
                // Only reset leaves this state
                state_d = BSRS_FAULT;
            end
            default:
            begin
                state_d = BSRS_GATED;
            end
        endcase
        run_d   = (state_d == BSRS_NORMAL);
        fault_d = (state_d == BSRS_FAULT);
    end

    always_ff @(posedge CLK_SYS or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            state_q    <= BSRS_GATED;
            dly_q      <= '0;
            ramp_q     <= '0;
            step_q     <= '0;
            idle_len_q <= '0;
            idle_q     <= '0;
            ov_pend_q  <= 1'b0;
            run_q      <= 1'b0;
            fault_q    <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            dly_q      <= dly_d;
            ramp_q     <= ramp_d;
            step_q     <= step_d;
            idle_len_q <= idle_len_d;
            idle_q     <= idle_d;
            ov_pend_q  <= ov_pend_d;
            run_q      <= run_d;
            fault_q    <= fault_d;
        end
    end

    // Outputs straight from flops; fault also serves upstream latch-off
    assign CYCLE_START   = start_q;
    assign CYCLE_ACTIVE  = act_q;
    assign RUN_INDICATOR = run_q;
    assign FAULT_LATCHED = fault_q;

endmodule : bsrs_sequencer

// ---- test/bsrs_checker.sv ----
// Output checker for the start-up ramp sequencer
`timescale 1ns/1ps
module bsrs_checker
#(
    parameter int CYCLE_CLKS = 8
)
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic BUS_UNDERVOLTAGE_GATE,
    input wire logic BUS_OVERVOLTAGE_TRIP,
    input wire logic REGULATION_FEEDBACK_INPUT,
    input wire logic CYCLE_START,
    input wire logic CYCLE_ACTIVE,
    input wire logic RUN_INDICATOR,
    input wire logic FAULT_LATCHED
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    int act_q;  // Active clocks of current cycle
    int act_d;  // Next count
    // Restart on each cycle start
    always_comb
    begin
        act_d = CYCLE_START ? 1 : (CYCLE_ACTIVE ? act_q + 1 : act_q);
    end
    // Count register
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            act_q <= 0;
        else
            act_q <= act_d;
    end
    len_max_a: assert property (CYCLE_ACTIVE && !CYCLE_START |-> act_q < CYCLE_CLKS)
        else $error("cycle longer than expected");
    len_full_a: assert property ($fell(CYCLE_ACTIVE) |-> act_q == CYCLE_CLKS)
        else $error("cycle cut short");
    chain_end_a: assert property (CYCLE_START && $past(CYCLE_ACTIVE) |-> act_q == CYCLE_CLKS)
        else $error("chained start mid-cycle");
    start_edge_a: assert property ($rose(CYCLE_ACTIVE) |-> CYCLE_START)
        else $error("active without start pulse");
    fault_hold_a: assert property (FAULT_LATCHED |=> FAULT_LATCHED)
        else $error("fault cleared without reset");
    fault_quiet_a: assert property (FAULT_LATCHED |-> !CYCLE_START && !RUN_INDICATOR)
        else $error("activity while faulted");
    fault_edge_a: assert property ($rose(FAULT_LATCHED) |-> !CYCLE_ACTIVE)
        else $error("fault set inside a cycle");
    uv_stop_a: assert property ((!BUS_UNDERVOLTAGE_GATE [*5] ##0 !CYCLE_ACTIVE) |=> !CYCLE_START)
        else $error("start while bus low");
    ov_idle_a: assert property ((BUS_OVERVOLTAGE_TRIP && !CYCLE_ACTIVE) [*3] |-> ##[0:3] FAULT_LATCHED)
        else $error("idle overvoltage not latched");
    ramp_gap_a: assert property (($fell(CYCLE_ACTIVE) && !RUN_INDICATOR) ##1 !RUN_INDICATOR |-> !CYCLE_ACTIVE)
        else $error("ramp gap below minimum");
endmodule : bsrs_checker

bind bsrs_sequencer bsrs_checker #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .BUS_UNDERVOLTAGE_GATE(BUS_UNDERVOLTAGE_GATE), .BUS_OVERVOLTAGE_TRIP(BUS_OVERVOLTAGE_TRIP),
    .REGULATION_FEEDBACK_INPUT(REGULATION_FEEDBACK_INPUT), .CYCLE_START(CYCLE_START),
    .CYCLE_ACTIVE(CYCLE_ACTIVE), .RUN_INDICATOR(RUN_INDICATOR), .FAULT_LATCHED(FAULT_LATCHED));

// ---- test/bsrs_plant.sv ----
// Power stage model: bus comparators, output and feedback path
`timescale 1ns/1ps
module bsrs_plant
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  bus_lvl,  // 0 low, 1 in range, 2 over
    input  wire logic [15:0] target,   // Output regulation level
    input  wire logic        active,
    input  wire logic        fault,
    output logic             uv_gate,
    output logic             ov_trip,
    output logic             fb
);
    logic [15:0] vout_q;  // Output charge
    logic [15:0] vout_d;
    logic        off_q;   // Upstream stage latched off
    logic        off_d;
    logic        on;      // Bus present
    // Output only charges while switching; drains when bus is gone
    always_comb
    begin
        off_d = off_q | fault;
        on = (bus_lvl != 2'h0) && !off_q;
        vout_d = on ? vout_q + {15'h0, active} : 16'h0;
    end
    // Comparator outputs change only at clock edges
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            off_q <= 1'b0;
            vout_q <= 16'h0;
            uv_gate <= 1'b0;
            ov_trip <= 1'b0;
            fb <= 1'b0;
        end
        else
        begin
            off_q <= off_d;
            vout_q <= vout_d;
            uv_gate <= on;
            ov_trip <= on && (bus_lvl == 2'h2);
            fb <= vout_d < target;
        end
    end
endmodule : bsrs_plant

// ---- test/bus_sense_startup_ramp_sequencer_test.sv ----
// Self-checking bench for the start-up ramp sequencer
`timescale 1ns/1ps
module bus_sense_startup_ramp_sequencer_test;
    localparam int N = 8, DLY = 20, RMP = 400, IS = 40, IM = 2;  // Shortened timing
    logic CLK_SYS, RST_N, BUS_UNDERVOLTAGE_GATE, BUS_OVERVOLTAGE_TRIP, REGULATION_FEEDBACK_INPUT;
    logic CYCLE_START, CYCLE_ACTIVE, RUN_INDICATOR, FAULT_LATCHED;
    logic [1:0]  lvl;  // Bus level request
    logic [15:0] tgt;  // Output target
    int n_fail, compares;
    bsrs_sequencer #(.CYCLE_CLKS(N), .START_DELAY_CLKS(DLY), .RAMP_CLKS(RMP), .IDLE_START_CLKS(IS),
        .IDLE_MIN_CLKS(IM)) dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
        .BUS_UNDERVOLTAGE_GATE(BUS_UNDERVOLTAGE_GATE), .BUS_OVERVOLTAGE_TRIP(BUS_OVERVOLTAGE_TRIP),
        .REGULATION_FEEDBACK_INPUT(REGULATION_FEEDBACK_INPUT), .CYCLE_START(CYCLE_START),
        .CYCLE_ACTIVE(CYCLE_ACTIVE), .RUN_INDICATOR(RUN_INDICATOR), .FAULT_LATCHED(FAULT_LATCHED));
    bsrs_plant u_plant (.clk(CLK_SYS), .rst_n(RST_N), .bus_lvl(lvl), .target(tgt), .active(CYCLE_ACTIVE),
        .fault(FAULT_LATCHED), .uv_gate(BUS_UNDERVOLTAGE_GATE), .ov_trip(BUS_OVERVOLTAGE_TRIP),
        .fb(REGULATION_FEEDBACK_INPUT));
    // 100 MHz clock
    initial
    begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    // Sample after the edge's updates have landed
    task automatic step();
        @(posedge CLK_SYS);
        #1;
    endtask : step
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic drive(input logic [1:0] l, input logic [15:0] t);
        @(posedge CLK_SYS);
        lvl <= l;
        tgt <= t;
        #1;
    endtask : drive
    function automatic logic pick(input int s);
        case (s)
            0: return CYCLE_START === 1'b1;
            1: return CYCLE_ACTIVE === 1'b0;
            2: return RUN_INDICATOR === 1'b1;
            default: return FAULT_LATCHED === 1'b1;
        endcase
    endfunction : pick
    // Bounded wait; running out ends the run
    task automatic wait_on(input int s, input int lim, output int n);
        n = 0;
        while (!pick(s) && n < lim)
        begin
            step();
            n++;
        end
        if (!pick(s))
        begin
            n_fail++;
            $display("ERROR wait %0d expected 1 seen 0", s);
            close_out();
        end
    endtask : wait_on
    task automatic t_reset();
        @(posedge CLK_SYS);
        RST_N <= 1'b0;
        lvl <= 2'h0;
        repeat (12) step();
        chk("outs_in_reset", 0, {CYCLE_START, CYCLE_ACTIVE, RUN_INDICATOR, FAULT_LATCHED});
        @(posedge CLK_SYS);
        RST_N <= 1'b1;
        repeat (4) step();
    endtask : t_reset
    task automatic t_ramp();
        int n, g, prev, last, k;
        drive(2'h1, 16'hffff);
        wait_on(0, DLY + 20, n);
        chk("start_delay", 1, n >= DLY && n <= DLY + 12);
        prev = IS;
        g = 0;
        last = 0;
        k = 0;
        while (RUN_INDICATOR !== 1'b1 && k < RMP + 50)
        begin
            step();
            k++;
            if (CYCLE_ACTIVE === 1'b0)
                g++;
            else if (g > 0)
            begin
                if (RUN_INDICATOR !== 1'b1)
                begin
                    chk("gap_order", 1, g <= prev && g >= IM);
                    last = g;
                end
                prev = g;
                g = 0;
            end
        end
        // Ramp that never hands over is a timeout
        if (RUN_INDICATOR !== 1'b1)
        begin
            n_fail++;
            $display("ERROR ramp_end expected 1 seen 0");
            close_out();
        end
        chk("ramp_len", 1, k >= RMP - 2 && k <= RMP + N + 6);
        chk("gap_floor", 1, last <= IM + 1);
    endtask : t_ramp
    task automatic t_normal();
        int n, c;
        wait_on(0, 2 * N + 4, n);
        c = 0;
        repeat (3 * N)
        begin
            step();
            c += int'(CYCLE_ACTIVE === 1'b1);
        end
        chk("back_to_back", 3 * N, c);
        wait_on(0, N + 2, n);
        drive(2'h0, 16'hffff);
        wait_on(1, N + 2, n);
        chk("uv_finish", 1, n >= N - 3 && n <= N + 1);
        c = 0;
        repeat (40)
        begin
            step();
            c += int'(CYCLE_START === 1'b1);
        end
        chk("uv_quiet", 0, c);
        chk("uv_run_low", 0, {31'h0, RUN_INDICATOR});
    endtask : t_normal
    task automatic t_fb_end();
        int n, c;
        // Bus drops mid-delay; the delay must start over on return
        drive(2'h1, 16'd24);
        repeat (DLY / 2) step();
        drive(2'h0, 16'd24);
        repeat (8) step();
        drive(2'h1, 16'd24);
        wait_on(0, DLY + 20, n);
        chk("delay_restart", 1, n >= DLY);
        wait_on(2, RMP + N, n);
        chk("fb_end", 1, n < RMP / 2);
        c = 0;
        repeat (20)
        begin
            step();
            c += int'(CYCLE_START === 1'b1);
        end
        chk("fb_low_idle", 0, c);
    endtask : t_fb_end
    task automatic t_ov_busy();
        int n;
        drive(2'h1, 16'hffff);
        wait_on(0, N + 10, n);
        drive(2'h2, 16'hffff);
        wait_on(3, N + 8, n);
        chk("ov_at_end", 1, n >= N - 2 && CYCLE_ACTIVE === 1'b0);
        drive(2'h1, 16'h0);
        repeat (30) step();
        chk("fault_kept", 2'h2, {FAULT_LATCHED, RUN_INDICATOR});
    endtask : t_ov_busy
    task automatic t_ov_idle();
        int n;
        t_reset();
        drive(2'h2, 16'h0);
        wait_on(3, 8, n);
        chk("ov_idle", 1, n >= 2 && n <= 6);
    endtask : t_ov_idle
    // Main sequence
    initial
    begin
        RST_N = 1'b0;
        lvl = 2'h0;
        tgt = 16'h0;
        n_fail = 0;
        compares = 0;
        t_reset();
        t_ramp();
        t_normal();
        t_fb_end();
        t_ov_busy();
        t_ov_idle();
        close_out();
    end
endmodule : bus_sense_startup_ramp_sequencer_test
